// File: src/scmb_map.svh
// register offsets, reset values and response codes of the command mailbox
// assumes byte-wide registers reached at their printed offsets
`ifndef SCMB_MAP_SVH
`define SCMB_MAP_SVH

`define SCMB_OFS_PROX3_TH_HIGH 8'h16
`define SCMB_OFS_PARAMETER_WRITE_MAILBOX_MBOX 8'h17
`define SCMB_OFS_COMMAND_MBOX 8'h18
`define SCMB_OFS_SEQ_RESPONSE 8'h20

`define SCMB_RST_BYTE 8'h00
`define SCMB_UNMAPPED_READ 8'h00

`define SCMB_ERR_BIT 7
`define SCMB_CNT_MSB 3
`define SCMB_ERR_INVALID_CMD 8'h80
`define SCMB_ERR_OVF_PROX1 8'h88
`define SCMB_ERR_OVF_PROX2 8'h89
`define SCMB_ERR_OVF_PROX3 8'h8A
`define SCMB_ERR_OVF_VIS 8'h8C
`define SCMB_ERR_OVF_IR 8'h8D
`define SCMB_ERR_OVF_AUX 8'h8E

`define SCMB_DEF_NOP_CODE 8'h00
`define SCMB_DEF_RESET_CODE 8'h01

`endif

// File: src/scmb_pkg.sv
// types shared by the command mailbox files
// assumes scmb_map.svh is on the include path
`include "scmb_map.svh"

package scmb_pkg;

   typedef logic [7:0] scmb_byte_t;

   typedef enum logic [0:0] {
      SCMB_PWR_AWAKE = 1'b0,
      SCMB_PWR_STANDBY = 1'b1
   } scmb_pwr_e;

   // overflow inputs, one bit per measurement, lowest index wins
   typedef enum logic [2:0] {
      SCMB_OVF_PROX1 = 3'h0,
      SCMB_OVF_PROX2 = 3'h1,
      SCMB_OVF_PROX3 = 3'h2,
      SCMB_OVF_VIS = 3'h3,
      SCMB_OVF_IR = 3'h4,
      SCMB_OVF_AUX = 3'h5
   } scmb_ovf_e;

endpackage : scmb_pkg

// File: src/scmb_thresh_cmp.sv
// threshold comparator for one proximity channel
// assumes result and threshold come from logic on the same clock
`timescale 1ns/1ps

module scmb_thresh_cmp #(
   parameter int WIDTH = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic result_valid,
   input wire logic [WIDTH-1:0] result,
   input wire logic [WIDTH-1:0] threshold,
   output logic crossed
);

   if (WIDTH < 2) begin : g_bad_width
      $error("scmb_thresh_cmp: WIDTH too small");
   end

   wire above = result_valid && (result > threshold);

   // one-cycle pulse per result that lies above the threshold
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         crossed <= 1'b0;
      end else begin
         crossed <= above;
      end
   end

endmodule : scmb_thresh_cmp

// File: src/scmb_top.sv
// host command mailbox in front of the internal sequencer of an optical sensor
// assumes an external serial slave turns bus transfers into byte register
// strobes on SYS_CLK, and that the sequencer answers on the same clock
//
// What this block does
// - each third-channel proximity result is compared against the 16-bit threshold whose high byte lives here, flagging a crossing.
// - an eight-bit read-write parameter mailbox hands values from the host to the sequencer.
// - every accepted write to the command register is passed to the sequencer for execution.
// - only a command register write brings the device out of standby.
// - an error loads the response register with a code whose top bit is set.
// - an error code stays until a reset or no-op command or a host write to the response register, and all other commands are dropped meanwhile.
// - threshold comparison and autonomous work carry on while an error is held.
// - without error or host write the response stays in 0x00-0x0F and its low nibble counts finished commands, wrapping.
// - an unrecognised command yields the invalid-command code 0x80.
// - converter overflow on proximity channels one to three yields 0x88, 0x89 and 0x8A.
// - converter overflow on visible, infrared and auxiliary yields 0x8C, 0x8D and 0x8E.
// - the four registers clear to zero at reset.
`timescale 1ns/1ps
`include "scmb_map.svh"

module scmb_top
   import scmb_pkg::*;
#(
   parameter scmb_byte_t NOP_CODE = `SCMB_DEF_NOP_CODE,
   parameter scmb_byte_t RESET_CODE = `SCMB_DEF_RESET_CODE,
   parameter int TH_WIDTH = 16
) (
   input wire logic SYS_CLK,
   input wire logic RST_N,
   input wire logic [7:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   input wire logic REG_WE,
   input wire logic REG_RE,
   output logic [7:0] REG_RDATA,
   output logic CMD_VALID,
   output logic [7:0] CMD_CODE,
   output logic [7:0] CMD_OPERAND,
   input wire logic SEQ_DONE,
   input wire logic SEQ_INVALID,
   input wire logic [5:0] SEQ_OVF,
   input wire logic SEQ_STANDBY_REQ,
   output logic STANDBY,
   input wire logic [7:0] PROX3_TH_LOW,
   input wire logic PROX3_RESULT_VALID,
   input wire logic [TH_WIDTH-1:0] PROX3_RESULT,
   output logic PROX3_CROSSED
);

   if (NOP_CODE == RESET_CODE) begin : g_bad_codes
      $error("scmb_top: NOP_CODE equals RESET_CODE");
   end
   if (TH_WIDTH != 16) begin : g_bad_width
      $error("scmb_top: TH_WIDTH must be 16");
   end

   scmb_byte_t prox3_threshold_high;
   scmb_byte_t parameter_write_mailbox;
   scmb_byte_t command_mailbox;
   scmb_byte_t sequencer_response;
   scmb_pwr_e pwr_state;
   scmb_byte_t next_response;
   scmb_byte_t ovf_code;

   // address decode
   wire sel_th = REG_ADDR == `SCMB_OFS_PROX3_TH_HIGH;
   wire sel_param = REG_ADDR == `SCMB_OFS_PARAMETER_WRITE_MAILBOX_MBOX;
   wire sel_cmd = REG_ADDR == `SCMB_OFS_COMMAND_MBOX;
   wire sel_resp = REG_ADDR == `SCMB_OFS_SEQ_RESPONSE;
   wire wr_th = REG_WE && sel_th;
   wire wr_param = REG_WE && sel_param;
   wire wr_cmd = REG_WE && sel_cmd;
   wire wr_resp = REG_WE && sel_resp;

   wire err_held = sequencer_response[`SCMB_ERR_BIT];
   wire is_recover = (REG_WDATA == NOP_CODE) || (REG_WDATA == RESET_CODE);
   // while an error is held only no-op and reset get through
   wire cmd_accept = wr_cmd && (!err_held || is_recover);
   // sequencer events are single-cycle pulses; a level would re-arm the error after a clear
   wire err_event = SEQ_INVALID || (|SEQ_OVF);

   // overflow code select, lowest measurement index first
   assign ovf_code =
      SEQ_OVF[SCMB_OVF_PROX1] ? `SCMB_ERR_OVF_PROX1 :
      SEQ_OVF[SCMB_OVF_PROX2] ? `SCMB_ERR_OVF_PROX2 :
      SEQ_OVF[SCMB_OVF_PROX3] ? `SCMB_ERR_OVF_PROX3 :
      SEQ_OVF[SCMB_OVF_VIS] ? `SCMB_ERR_OVF_VIS :
      SEQ_OVF[SCMB_OVF_IR] ? `SCMB_ERR_OVF_IR :
      `SCMB_ERR_OVF_AUX;

   wire scmb_byte_t err_code = SEQ_INVALID ? `SCMB_ERR_INVALID_CMD : ovf_code;

   wire [3:0] count_inc = sequencer_response[`SCMB_CNT_MSB:0] + 4'h1;

   // a held error keeps its first code; a new error beats a host write only when no error is held
   // with no error held, a host write to the response register loses against a sequencer event
   // in the same cycle, so software that presets the counter may miss one
   always_comb begin
      next_response = sequencer_response;
      if (err_held) begin
         if (cmd_accept) begin
            next_response = `SCMB_RST_BYTE;
         end else if (wr_resp) begin
            next_response = REG_WDATA;
         end
      end else if (err_event) begin
         next_response = err_code;
      end else if (SEQ_DONE) begin
         next_response = {4'h0, count_inc};
      end else if (wr_resp) begin
         next_response = REG_WDATA;
      end
   end

   // unmapped offsets read as zero so a probing host sees no stale data
   wire scmb_byte_t rd_mux =
      sel_th ? prox3_threshold_high :
      sel_param ? parameter_write_mailbox :
      sel_cmd ? command_mailbox :
      sel_resp ? sequencer_response :
      `SCMB_UNMAPPED_READ;

   // only the high byte lives here; a host that rewrites both halves while
   // results arrive may see a mixed threshold for one measurement
   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         prox3_threshold_high <= `SCMB_RST_BYTE;
      end else if (wr_th) begin
         prox3_threshold_high <= REG_WDATA;
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         parameter_write_mailbox <= `SCMB_RST_BYTE;
      end else if (wr_param) begin
         parameter_write_mailbox <= REG_WDATA;
      end
   end

   // command register reads back every write, dropped ones included
   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         command_mailbox <= `SCMB_RST_BYTE;
      end else if (wr_cmd) begin
         command_mailbox <= REG_WDATA;
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         sequencer_response <= `SCMB_RST_BYTE;
      end else begin
         sequencer_response <= next_response;
      end
   end

   // one pulse per accepted write; the sequencer must take it in that cycle
   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         CMD_VALID <= 1'b0;
      end else begin
         CMD_VALID <= cmd_accept;
      end
   end

   // the operand is the mailbox as it stands when the command is written
   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         CMD_CODE <= `SCMB_RST_BYTE;
         CMD_OPERAND <= `SCMB_RST_BYTE;
      end else if (cmd_accept) begin
         CMD_CODE <= REG_WDATA;
         CMD_OPERAND <= parameter_write_mailbox;
      end
   end

   // read data is held between reads so a slow serial slave can shift it out
   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         REG_RDATA <= `SCMB_UNMAPPED_READ;
      end else if (REG_RE) begin
         REG_RDATA <= rd_mux;
      end
   end

   // standby: entered on sequencer request, left only on a command write
   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         pwr_state <= SCMB_PWR_AWAKE;
      end else begin
         case (pwr_state)
            SCMB_PWR_AWAKE: begin
               if (SEQ_STANDBY_REQ && !wr_cmd) pwr_state <= SCMB_PWR_STANDBY;
            end
            SCMB_PWR_STANDBY: begin
               if (wr_cmd) pwr_state <= SCMB_PWR_AWAKE;
            end
            default: pwr_state <= SCMB_PWR_AWAKE;
         endcase
      end
   end

   // the pin mirrors the next state so it follows the state flip-flop without lag
   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         STANDBY <= 1'b0;
      end else begin
         STANDBY <= (pwr_state == SCMB_PWR_STANDBY) ? !wr_cmd
                    : (SEQ_STANDBY_REQ && !wr_cmd);
      end
   end

   // comparison ignores the error state so autonomous work is not disturbed
   scmb_thresh_cmp #(
      .WIDTH(TH_WIDTH)
   ) u_prox3_cmp (
      .clk(SYS_CLK),
      .rst_n(RST_N),
      .result_valid(PROX3_RESULT_VALID),
      .result(PROX3_RESULT),
      .threshold({prox3_threshold_high, PROX3_TH_LOW}),
      .crossed(PROX3_CROSSED)
   );

endmodule : scmb_top

// File: verif/scmb_top_checker.sv
// port-level assertions for the command mailbox top
// assumes it is bound into scmb_top and shares its one clock
`timescale 1ns/1ps
module scmb_top_checker #(
   parameter logic [7:0] NOP_CODE = 8'h00,
   parameter logic [7:0] RESET_CODE = 8'h01,
   parameter int TH_WIDTH = 16
) (
   input wire logic SYS_CLK,
   input wire logic RST_N,
   input wire logic [7:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   input wire logic REG_WE,
   input wire logic REG_RE,
   input wire logic [7:0] REG_RDATA,
   input wire logic CMD_VALID,
   input wire logic [7:0] CMD_CODE,
   input wire logic [7:0] CMD_OPERAND,
   input wire logic SEQ_DONE,
   input wire logic SEQ_INVALID,
   input wire logic [5:0] SEQ_OVF,
   input wire logic SEQ_STANDBY_REQ,
   input wire logic STANDBY,
   input wire logic [7:0] PROX3_TH_LOW,
   input wire logic PROX3_RESULT_VALID,
   input wire logic [TH_WIDTH-1:0] PROX3_RESULT,
   input wire logic PROX3_CROSSED
);
   wire cmd_wr = REG_WE && REG_ADDR == 8'h18;
   wire keep_cmd = REG_WDATA != NOP_CODE && REG_WDATA != RESET_CODE;
   default clocking cb @(posedge SYS_CLK);
   endclocking
   default disable iff (!RST_N);
   property p_cmd; CMD_VALID |-> $past(cmd_wr) && CMD_CODE == $past(REG_WDATA); endproperty
   a_cmd: assert property (p_cmd) else $error("command pulse without write");
   property p_opnd; REG_WE && REG_ADDR == 8'h17 ##1 cmd_wr
      |=> !CMD_VALID || CMD_OPERAND == $past(REG_WDATA, 2); endproperty
   a_opnd: assert property (p_opnd) else $error("operand not mailbox");
   // two quiet cycles keep a clearing command out of the way
   property p_drop; SEQ_OVF != 6'h00 && !REG_WE ##1 !REG_WE ##1 cmd_wr && keep_cmd
      |=> !CMD_VALID; endproperty
   a_drop: assert property (p_drop) else $error("command passed during error");
   property p_wake; $fell(STANDBY) |-> $past(cmd_wr); endproperty
   a_wake: assert property (p_wake) else $error("woken without command");
   property p_sleep; SEQ_STANDBY_REQ && !cmd_wr |=> STANDBY; endproperty
   a_sleep: assert property (p_sleep) else $error("standby not entered");
   property p_rise; STANDBY && cmd_wr && !SEQ_STANDBY_REQ |=> !STANDBY; endproperty
   a_rise: assert property (p_rise) else $error("command did not wake");
   property p_range; REG_RE && REG_ADDR == 8'h20 |=> REG_RDATA[6:4] == 3'h0; endproperty
   a_range: assert property (p_range) else $error("response out of range");
   property p_err; (SEQ_INVALID || SEQ_OVF != 6'h00) && !REG_WE
      ##1 REG_RE && REG_ADDR == 8'h20 |=> REG_RDATA[7]; endproperty
   a_err: assert property (p_err) else $error("error code lacks top bit");
   property p_cross; PROX3_CROSSED |-> $past(PROX3_RESULT_VALID && PROX3_RESULT != '0);
   endproperty
   a_cross: assert property (p_cross) else $error("crossing without result");
   c_cmd: cover property (CMD_VALID);
   c_wake: cover property ($fell(STANDBY));
   c_cross: cover property (PROX3_CROSSED);
endmodule : scmb_top_checker

// File: verif/scmb_seq_model.sv
// sequencer stand-in: one cycle after hand-over, finishes each command or flags BAD_CODE invalid
// assumes commands arrive as one-cycle pulses on the mailbox clock
`timescale 1ns/1ps
module scmb_seq_model #(
   parameter logic [7:0] BAD_CODE = 8'hFF
) (
   input wire logic clk,
   input wire logic cmd_valid,
   input wire logic [7:0] cmd_code,
   output logic done = 1'b0,
   output logic invalid = 1'b0
);
   // only one code is unknown, so the error path is reached on purpose
   always @(posedge clk) begin
      done <= cmd_valid && cmd_code != BAD_CODE;
      invalid <= cmd_valid && cmd_code == BAD_CODE;
   end
endmodule : scmb_seq_model

// File: verif/scmb_top_tb.sv
// self-checking bench for the command mailbox
// assumes the sequencer model answers every command on the next cycle
`timescale 1ns/1ps
module scmb_top_tb;
   logic clk = 1'b0, rst_n = 1'b0, we = 1'b0, re = 1'b0, rv = 1'b0, sreq = 1'b0;
   logic [7:0] addr = 8'h00, wd = 8'h00, thl = 8'h34, rdat, code, opnd;
   logic [5:0] ovf = 6'h00;
   logic [15:0] res = 16'h0000;
   logic cv, done, inval, stby, crossed;
   int n_errors = 0, n_tests = 0;
   logic [7:0] reg_ofs[4] = '{8'h16, 8'h17, 8'h18, 8'h20};
   logic [7:0] ovf_codes[6] = '{8'h88, 8'h89, 8'h8A, 8'h8C, 8'h8D, 8'h8E};
   always #50 clk = ~clk;
   scmb_top uut (.SYS_CLK(clk), .RST_N(rst_n), .REG_ADDR(addr), .REG_WDATA(wd), .REG_WE(we),
      .REG_RE(re), .REG_RDATA(rdat), .CMD_VALID(cv), .CMD_CODE(code), .CMD_OPERAND(opnd),
      .SEQ_DONE(done), .SEQ_INVALID(inval), .SEQ_OVF(ovf), .SEQ_STANDBY_REQ(sreq),
      .STANDBY(stby), .PROX3_TH_LOW(thl), .PROX3_RESULT_VALID(rv), .PROX3_RESULT(res),
      .PROX3_CROSSED(crossed));
   scmb_seq_model seq (.clk(clk), .cmd_valid(cv), .cmd_code(code), .done(done), .invalid(inval));
   task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task tick(input int n);
      repeat (n) @(posedge clk);
      #10;
   endtask : tick
   // the write strobe is never lowered here, so accesses chain without a double assignment
   task wr(input logic [7:0] a, input logic [7:0] d);
      addr = a;
      wd = d;
      we = 1'b1;
      re = 1'b0;
      tick(1);
   endtask : wr
   task rd(input logic [7:0] a, input logic [7:0] exp, input string what);
      addr = a;
      we = 1'b0;
      re = 1'b1;
      tick(1);
      chk(what, exp, rdat);
   endtask : rd
   task idle(input int n);
      we = 1'b0;
      re = 1'b0;
      tick(n);
   endtask : idle
   task cmd(input logic [7:0] c, input logic [7:0] exp);
      wr(8'h18, c);
      chk("cmd_valid", exp, {7'h00, cv});
      idle(3);
   endtask : cmd
   task t_regs;
      foreach (reg_ofs[i]) rd(reg_ofs[i], 8'h00, "reset value");
      wr(8'h16, 8'h12);
      wr(8'h30, 8'h77);
      rd(8'h16, 8'h12, "th_high");
      rd(8'h30, 8'h00, "unmapped");
   endtask : t_regs
   task t_cmd;
      wr(8'h17, 8'h3C);
      rd(8'h17, 8'h3C, "mailbox");
      wr(8'h17, 8'hC3);
      for (int i = 1; i <= 17; i++) begin
         cmd(i[7:0] + 8'h10, 8'h01);
         rd(8'h20, i[7:0] & 8'h0F, "count");
      end
      chk("operand", 8'hC3, opnd);
      chk("code", 8'h21, code);
   endtask : t_cmd
   task t_err;
      for (int i = 0; i < 6; i++) begin
         ovf = 6'h3F << i;
         idle(1);
         ovf = 6'h00;
         rd(8'h20, ovf_codes[i], "error code");
         res = 16'h1233 + 16'(i);
         rv = 1'b1;
         wr(8'h18, 8'h10);
         rv = 1'b0;
         chk("dropped", 8'h00, {7'h00, cv});
         chk("crossed", {7'h00, i > 1}, {7'h00, crossed});
         cmd(i[0] ? 8'h01 : 8'h00, 8'h01);
         rd(8'h20, 8'h01, "cleared");
      end
      cmd(8'hFF, 8'h01);
      rd(8'h20, 8'h80, "invalid");
   endtask : t_err
   task t_stby;
      sreq = 1'b1;
      idle(1);
      sreq = 1'b0;
      wr(8'h17, 8'h00);
      rd(8'h20, 8'h80, "held");
      chk("standby", 8'h01, {7'h00, stby});
      cmd(8'h01, 8'h01);
      chk("woken", 8'h00, {7'h00, stby});
   endtask : t_stby
   // reset in mid-run, with every register holding a nonzero value
   task t_rst;
      wr(8'h17, 8'h5A);
      rst_n = 1'b0;
      idle(2);
      rst_n = 1'b1;
      foreach (reg_ofs[i]) rd(reg_ofs[i], 8'h00, "reset value");
      chk("code reset", 8'h00, code);
   endtask : t_rst
   task results;
      $display("errors %0d tests %0d", n_errors, n_tests);
      if (n_errors == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : results
   initial begin
      repeat (20) @(posedge clk);
      #10;
      rst_n = 1'b1;
      t_regs();
      t_cmd();
      t_err();
      t_stby();
      t_rst();
      results();
   end
endmodule : scmb_top_tb
bind scmb_top scmb_top_checker #(.NOP_CODE(NOP_CODE), .RESET_CODE(RESET_CODE),
   .TH_WIDTH(TH_WIDTH)) chk_i (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR),
   .REG_WDATA(REG_WDATA), .REG_WE(REG_WE), .REG_RE(REG_RE), .REG_RDATA(REG_RDATA),
   .CMD_VALID(CMD_VALID), .CMD_CODE(CMD_CODE), .CMD_OPERAND(CMD_OPERAND),
   .SEQ_DONE(SEQ_DONE), .SEQ_INVALID(SEQ_INVALID), .SEQ_OVF(SEQ_OVF),
   .SEQ_STANDBY_REQ(SEQ_STANDBY_REQ), .STANDBY(STANDBY), .PROX3_TH_LOW(PROX3_TH_LOW),
   .PROX3_RESULT_VALID(PROX3_RESULT_VALID), .PROX3_RESULT(PROX3_RESULT),
   .PROX3_CROSSED(PROX3_CROSSED));
